// *** rtl/ucs_config_space.sv ***
// Upper type-1 header and extended capability register bank.
// Assumes synchronous inputs; each requester holds req until ack.
//
// Behaviour
// R1: Offsets 100h to FFFh are decoded as extended space, 3840 bytes in all.
// R2: The error-reporting capability header sits at 100h with ID 0001h.
// R3: The virtual channel capability header sits at 150h with ID 0002h.
// R4: Subtractive decode drops the express capability from the pointer chain.
// R5: Subtractive decode makes express capability and extended words reserved.
// R6: A product-data operation moves the data word to or from the EEPROM.
// R7: Error-report control is reachable by SMBus but never preloaded.
// R8: This layout is presented only in transparent mode.
// R9: Reserved offsets read zero and ignore writes on every path.
`timescale 1ns/1ps
`default_nettype none
module ucs_config_space
  import ucs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Mode
  input  wire logic        transparent_mode,
  input  wire logic        subtractive_en,
  // Configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic [31:0]      cfg_rdata,
  // SMBus slave access
  input  wire logic        smb_req,
  input  wire logic        smb_we,
  input  wire logic [11:0] smb_addr,
  input  wire logic [3:0]  smb_be,
  input  wire logic [31:0] smb_wdata,
  output logic             smb_ack,
  output logic [31:0]      smb_rdata,
  // EEPROM preload
  input  wire logic        eep_valid,
  input  wire logic [11:0] eep_addr,
  input  wire logic [31:0] eep_data,
  output logic             eep_ack,
  // Product-data EEPROM transfer
  output logic             vpd_req,
  output logic             vpd_write,
  output logic [14:0]      vpd_addr,
  output logic [31:0]      vpd_wdata,
  input  wire logic        vpd_done,
  input  wire logic [31:0] vpd_rdata,
  // Error events and summaries
  input  wire logic [31:0] fatal_evt,
  input  wire logic [31:0] recov_evt,
  input  wire logic [31:0] sec_fatal_evt,
  output logic             fatal_pending,
  output logic             recov_pending
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0] regs     [NREG];
  logic [31:0] next_reg [NREG];

  // ----------------------------------------------------------------
  // Arbitration: config first, then SMBus, then preload
  // ----------------------------------------------------------------
  wire        take_cfg = cfg_req & ~cfg_ack;
  wire        take_smb = smb_req & ~smb_ack & ~take_cfg;
  wire        take_eep = eep_valid & ~eep_ack & ~take_cfg & ~take_smb;
  wire        take_bus = take_cfg | take_smb;
  wire [11:0] acc_addr = take_cfg ? cfg_addr : smb_addr;
  wire        acc_we   = take_cfg ? cfg_we : smb_we;
  wire [3:0]  acc_be   = take_cfg ? cfg_be : smb_be;
  wire [31:0] acc_wd   = take_cfg ? cfg_wdata : smb_wdata;
  wire [31:0] be_mask  = {{8{acc_be[3]}}, {8{acc_be[2]}},
                          {8{acc_be[1]}}, {8{acc_be[0]}}};

  // ----------------------------------------------------------------
  // Decode, with indirect redirection through the data window
  // ----------------------------------------------------------------
  wire [5:0] raw_idx = ucs_index(acc_addr); // R1
  wire [5:0] ind_idx = ucs_index(regs[IDX_ECFG_ADDR][11:0]);
  wire [5:0] acc_idx = (raw_idx != IDX_ECFG_DATA) ? raw_idx :
                       (ind_idx == IDX_ECFG_DATA) ? IDX_MISS : ind_idx;
  wire       raw_hid = (raw_idx != IDX_MISS) && SUB_RSVD[raw_idx];
  wire       acc_hid = (acc_idx != IDX_MISS) && SUB_RSVD[acc_idx];
  // Word is visible only in transparent mode and when not hidden
  wire       acc_ok  = transparent_mode & (acc_idx != IDX_MISS) & // R8 R9
                       ~(subtractive_en & (raw_hid | acc_hid));   // R5
  wire       bus_wr  = take_bus & acc_we & acc_ok;
  wire [5:0] eep_idx = ucs_index(eep_addr);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] word_rd = (acc_idx == IDX_MISS) ? 32'h0000_0000 : regs[acc_idx];
  // Skip the express capability in the chain under subtractive decode
  wire        skip_exp = subtractive_en & (acc_idx == IDX_SUBSYS_CAP);
  wire [31:0] chain_rd = skip_exp ?
    {word_rd[31:16], regs[IDX_EXP_CAP][15:8], word_rd[7:0]} : word_rd; // R4
  wire [31:0] rd_val   = acc_ok ? chain_rd : 32'h0000_0000; // R9

  // ----------------------------------------------------------------
  // Product-data operation control
  // ----------------------------------------------------------------
  wire vpd_start = bus_wr & (acc_idx == IDX_VPD_CAP) & ~vpd_req;
  wire vpd_end   = vpd_req & vpd_done;
  // Flag and address as written into the capability word
  wire [31:0] vpd_merged  = (regs[IDX_VPD_CAP] & ~be_mask) | (acc_wd & be_mask);
  wire        merged_flag = vpd_merged[VPD_FLAG_BIT];
  wire [14:0] merged_addr = vpd_merged[VPD_ADDR_LSB +: VPD_ADDR_W];

  // ----------------------------------------------------------------
  // Next value per word
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_word
      localparam logic [5:0] ME = 6'(gi);
      wire        wr_me  = bus_wr & (acc_idx == ME);
      wire        eep_me = take_eep & (eep_idx == ME) & EEP_LOAD[gi]; // R7
      wire [31:0] merged = (regs[gi] & ~be_mask) | (acc_wd & be_mask);
      wire [31:0] clr    = wr_me ? (acc_wd & be_mask) : 32'h0000_0000;
      wire [31:0] set    = (ME == IDX_UNC_STS)  ? fatal_evt :
                           (ME == IDX_COR_STS)  ? recov_evt :
                           (ME == IDX_SUNC_STS) ? sec_fatal_evt : 32'h0000_0000;
      // SMBus may program read-only words, except the AER header
      wire        smb_ro = wr_me & take_smb & (ME != IDX_AER_HDR);
      if (REG_KIND[gi] == K_W1C) begin : g_w1c
        // Set wins over a same-cycle clear
        assign next_reg[gi] = (regs[gi] & ~clr) | set;
      end else if (REG_KIND[gi] == K_RO) begin : g_ro
        assign next_reg[gi] = eep_me ? eep_data : smb_ro ? merged : regs[gi];
      end else if (ME == IDX_VPD_CAP) begin : g_vpdc
        // Flag and address start an operation; the device flips the flag
        assign next_reg[gi] =
          vpd_start ? {merged[31:16], regs[gi][15:0]} : // R6
          vpd_end   ? {~vpd_write, regs[gi][30:0]} :    // R6
          eep_me    ? eep_data : regs[gi];
      end else if (ME == IDX_ECFG_DATA) begin : g_win
        assign next_reg[gi] = 32'h0000_0000;
      end else if (ME == IDX_VPD_DATA) begin : g_vpdd
        assign next_reg[gi] = (vpd_end & ~vpd_write) ? vpd_rdata : // R6
                              wr_me ? merged : eep_me ? eep_data : regs[gi];
      end else begin : g_rw
        assign next_reg[gi] = wr_me ? merged : eep_me ? eep_data : regs[gi];
      end
    end
  endgenerate

  // Word array update
  always_ff @(posedge clk) begin
    for (int i = 0; i < NREG; i++) begin
      regs[i] <= rstn ? next_reg[i] : ucs_reset(i); // R2 R3
    end
  end

  // ----------------------------------------------------------------
  // Access answers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_ack   <= 1'b0;
      smb_ack   <= 1'b0;
      eep_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      smb_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= take_cfg;
      smb_ack <= take_smb;
      eep_ack <= take_eep;
      if (take_cfg) cfg_rdata <= rd_val;
      if (take_smb) smb_rdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // EEPROM transfer request and error summaries
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      vpd_req       <= 1'b0;
      vpd_write     <= 1'b0;
      vpd_addr      <= 15'h0000;
      vpd_wdata     <= 32'h0000_0000;
      fatal_pending <= 1'b0;
      recov_pending <= 1'b0;
    end else begin
      if (vpd_start) begin
        vpd_req   <= 1'b1; // R6
        vpd_write <= merged_flag;
        vpd_addr  <= merged_addr;
        vpd_wdata <= regs[IDX_VPD_DATA];
      end else if (vpd_end) begin
        vpd_req <= 1'b0;
      end
      fatal_pending <= |(regs[IDX_UNC_STS] & ~regs[IDX_UNC_MSK]);
      recov_pending <= |(regs[IDX_COR_STS] & ~regs[IDX_COR_MSK]);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire cfg_rd  = take_cfg & ~cfg_we & transparent_mode;
  wire plain   = cfg_rd & ~subtractive_en;

  property p_ext_reserved;
    plain && cfg_addr >= EXT_BASE && ucs_index(cfg_addr) == IDX_MISS
      |=> cfg_ack && cfg_rdata == 32'h0000_0000;
  endproperty
  a_ext_reserved: assert property (p_ext_reserved) // R1
    else $error("extended reserved read not zero");

  property p_aer_hdr;
    plain && cfg_addr == 12'h100
      |=> cfg_rdata == $past(regs[IDX_AER_HDR]) && cfg_rdata[15:0] == 16'h0001;
  endproperty
  a_aer_hdr: assert property (p_aer_hdr) // R2
    else $error("error-report header wrong");

  property p_vc_hdr;
    plain && cfg_addr == 12'h150 && regs[IDX_VC_HDR] == VC_HDR_RST
      |=> cfg_rdata[15:0] == 16'h0002;
  endproperty
  a_vc_hdr: assert property (p_vc_hdr) // R3
    else $error("channel header wrong");

  property p_chain_skip;
    cfg_rd && subtractive_en && cfg_addr == 12'h0A8
      |=> cfg_rdata[15:8] == $past(regs[IDX_EXP_CAP][15:8]);
  endproperty
  a_chain_skip: assert property (p_chain_skip) // R4
    else $error("express capability not skipped");

  property p_sub_hidden;
    cfg_rd && subtractive_en && (cfg_addr == 12'h100 || cfg_addr == 12'h0B0)
      |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_sub_hidden: assert property (p_sub_hidden) // R5
    else $error("hidden word not reserved");

  sequence s_vpd_go;
    vpd_start;
  endsequence
  sequence s_vpd_busy;
    vpd_req && vpd_addr == $past(merged_addr);
  endsequence
  property p_vpd_start;
    s_vpd_go |=> s_vpd_busy;
  endproperty
  a_vpd_start: assert property (p_vpd_start) // R6
    else $error("transfer not requested");

  property p_vpd_read;
    vpd_end && !vpd_write
      |=> regs[IDX_VPD_DATA] == $past(vpd_rdata) && regs[IDX_VPD_CAP][31];
  endproperty
  a_vpd_read: assert property (p_vpd_read) // R6
    else $error("read data not captured");

  property p_ctl_no_load;
    take_eep && eep_addr == 12'h118 |=> $stable(regs[IDX_AER_CTL]);
  endproperty
  a_ctl_no_load: assert property (p_ctl_no_load) // R7
    else $error("control word was preloaded");

  property p_opaque;
    take_cfg && !cfg_we && !transparent_mode
      |=> cfg_ack && cfg_rdata == 32'h0000_0000;
  endproperty
  a_opaque: assert property (p_opaque) // R8
    else $error("non-transparent read not zero");

  property p_rsvd_write;
    take_cfg && cfg_we && ucs_index(cfg_addr) == IDX_MISS
      |=> regs[IDX_AER_CTL] == $past(regs[IDX_AER_CTL])
          && regs[IDX_UNC_MSK] == $past(regs[IDX_UNC_MSK]);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write) // R9
    else $error("reserved write changed a word");

  // A fatal event is never lost, even under a same-cycle clear
  property p_set_wins;
    fatal_evt != 32'h0000_0000
      |=> (regs[IDX_UNC_STS] & $past(fatal_evt)) == $past(fatal_evt);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("fatal event lost");

  // Each config answer is a single-cycle pulse
  property p_ack_pulse;
    cfg_ack |=> !cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("config ack stood too long");
endmodule : ucs_config_space
`default_nettype wire

// *** shared/ucs_pkg.sv ***
// Constants for the upper and extended configuration space bank.
// Assumes a 12-bit byte address and 32-bit register words.
`default_nettype none
package ucs_pkg;
  // ----------------------------------------------------------------
  // Map geometry
  // ----------------------------------------------------------------
  localparam int           NREG     = 49;
  localparam int           IDX_W    = 6;
  localparam logic [5:0]   IDX_MISS = 6'h3F;
  localparam logic [11:0]  EXT_BASE = 12'h100;
  localparam logic [11:0]  EXT_LAST = 12'hFFF;
  localparam logic [1:0]   K_RO = 2'h0, K_RW = 2'h1, K_W1C = 2'h2, K_SP = 2'h3;
  // ----------------------------------------------------------------
  // Word offsets and access kinds, by index
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_OFF [NREG] = '{
    12'h0A0, 12'h0A4, 12'h0A8, 12'h0AC, 12'h0B0, 12'h0B4, 12'h0B8,
    12'h0BC, 12'h0C0, 12'h0CC, 12'h0D0, 12'h0D4, 12'h0D8, 12'h0DC,
    12'h0E0, 12'h0E4, 12'h0F0, 12'h0F4, 12'h0F8, 12'h0FC, 12'h100,
    12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118, 12'h11C,
    12'h120, 12'h124, 12'h128, 12'h12C, 12'h130, 12'h134, 12'h138,
    12'h13C, 12'h140, 12'h144, 12'h148, 12'h150, 12'h154, 12'h158,
    12'h15C, 12'h160, 12'h164, 12'h168, 12'h300, 12'h304, 12'h310};
  localparam logic [1:0] REG_KIND [NREG] = '{
    K_RW, K_RW, K_RO, K_RW, K_RO, K_RO, K_RW, K_RO, K_RW, K_RW,
    K_RW, K_RW, K_SP, K_RW, K_RW, K_SP, K_RW, K_RW, K_RW, K_RW,
    K_RO, K_W1C, K_RW, K_RW, K_W1C, K_RW, K_RW, K_RO, K_RO, K_RO,
    K_RO, K_W1C, K_RW, K_RW, K_RW, K_RO, K_RO, K_RO, K_RO, K_RO,
    K_RO, K_RO, K_RW, K_RO, K_RW, K_RO, K_RW, K_RW, K_RW};
  // Words the EEPROM preload may write
  localparam logic [NREG-1:0] EEP_LOAD = 49'h1_0000_005F_FFFF;
  // Words hidden while subtractive decode is on
  localparam logic [NREG-1:0] SUB_RSVD = 49'h1_FFFF_FFF0_C1F0;
  // ----------------------------------------------------------------
  // Named indices
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_SUBSYS_CAP = 6'h02, IDX_EXP_CAP   = 6'h04;
  localparam logic [5:0] IDX_VPD_CAP    = 6'h0C, IDX_VPD_DATA  = 6'h0D;
  localparam logic [5:0] IDX_ECFG_ADDR  = 6'h0E, IDX_ECFG_DATA = 6'h0F;
  localparam logic [5:0] IDX_AER_HDR    = 6'h14, IDX_UNC_STS   = 6'h15;
  localparam logic [5:0] IDX_UNC_MSK    = 6'h16, IDX_COR_STS   = 6'h18;
  localparam logic [5:0] IDX_COR_MSK    = 6'h19, IDX_AER_CTL   = 6'h1A;
  localparam logic [5:0] IDX_SUNC_STS   = 6'h1F, IDX_VC_HDR    = 6'h27;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CAP_NEXT_LSB = 8;
  localparam int          VPD_FLAG_BIT = 31;
  localparam int          VPD_ADDR_LSB = 16;
  localparam int          VPD_ADDR_W   = 15;
  localparam logic [31:0] AER_HDR_RST  = 32'h1501_0001;
  localparam logic [31:0] VC_HDR_RST   = 32'h0001_0002;
  localparam logic [31:0] VPD_CAP_RST  = 32'h0000_F003;

  // Word index of a byte address, IDX_MISS when unmapped
  function automatic logic [5:0] ucs_index(input logic [11:0] a);
    logic [5:0] r;
    r = IDX_MISS;
    for (int i = 0; i < NREG; i++) begin
      if (REG_OFF[i] == {a[11:2], 2'h0}) r = 6'(i);
    end
    return r;
  endfunction : ucs_index

  // Reset value of a word
  function automatic logic [31:0] ucs_reset(input int i);
    if (i == int'(IDX_AER_HDR)) return AER_HDR_RST;
    if (i == int'(IDX_VC_HDR))  return VC_HDR_RST;
    if (i == int'(IDX_VPD_CAP)) return VPD_CAP_RST;
    return 32'h0000_0000;
  endfunction : ucs_reset
endpackage : ucs_pkg
`default_nettype wire

// *** testbench/test_bridge_upper_and_extended_config_space.sv ***
// Self-checking bench for the upper and extended configuration bank.
// Assumes the EEPROM engine model answers product-data transfers.
`timescale 1ns/1ps
`default_nettype none
module test_bridge_upper_and_extended_config_space;
  import ucs_pkg::*;
  logic clk, rstn, tmode, sub_en, we_b, vpd_req, vpd_write, vpd_done;
  logic cfg_ack, smb_ack, eep_ack, fpend, rpend;
  logic [2:0] req_b;
  logic [3:0] be_b;
  logic [11:0] a_b;
  logic [14:0] vpd_addr;
  logic [31:0] wd_b, cfg_rdata, smb_rdata, vpd_wdata, vpd_rdata, d;
  logic [31:0] fev, rev, sev;
  int failures, n_tests;

  ucs_config_space dut (.clk(clk), .rstn(rstn), .transparent_mode(tmode),
    .subtractive_en(sub_en), .cfg_req(req_b[0]), .cfg_we(we_b), .cfg_addr(a_b),
    .cfg_be(be_b), .cfg_wdata(wd_b), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .smb_req(req_b[1]), .smb_we(we_b), .smb_addr(a_b), .smb_be(be_b),
    .smb_wdata(wd_b), .smb_ack(smb_ack), .smb_rdata(smb_rdata),
    .eep_valid(req_b[2]), .eep_addr(a_b), .eep_data(wd_b), .eep_ack(eep_ack),
    .vpd_req(vpd_req), .vpd_write(vpd_write), .vpd_addr(vpd_addr),
    .vpd_wdata(vpd_wdata), .vpd_done(vpd_done), .vpd_rdata(vpd_rdata),
    .fatal_evt(fev), .recov_evt(rev), .sec_fatal_evt(sev),
    .fatal_pending(fpend), .recov_pending(rpend));

  ucs_vpd_model #(.DELAY(5)) eng (.clk(clk), .vpd_req(vpd_req),
    .vpd_write(vpd_write), .vpd_addr(vpd_addr), .vpd_done(vpd_done),
    .vpd_rdata(vpd_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  // One access on path 0 config, 1 SMBus, 2 preload; held through ack
  task automatic acc(input int p, input logic we, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(negedge clk);
    we_b = we;
    a_b = a;
    wd_b = wd;
    req_b = 3'(1 << p);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((p == 0 ? cfg_ack : p == 1 ? smb_ack : eep_ack) !== 1'b1 && n < 40);
    rd = (p == 0) ? cfg_rdata : smb_rdata;
    if (n >= 40) chk("ack", 1, 0);
    @(posedge clk);
    @(negedge clk);
    req_b = 3'b000;
  endtask : acc

  task automatic rchk(input int p, input logic [11:0] a, input logic [31:0] e,
                      input string nm);
    logic [31:0] r;
    acc(p, 1'b0, a, 32'h0000_0000, r);
    chk(nm, e, r);
  endtask : rchk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    rchk(0, 12'h100, 32'h1501_0001, "aer_hdr");
    rchk(0, 12'h150, 32'h0001_0002, "vc_hdr");
    rchk(0, 12'h0D8, 32'h0000_F003, "vpd_cap");
    acc(0, 1'b1, 12'h100, 32'hFFFF_FFFF, d);
    rchk(0, 12'h100, 32'h1501_0001, "aer_hdr_ro");
    acc(0, 1'b1, 12'h310, 32'h1234_5678, d);
    rchk(0, 12'h310, 32'h1234_5678, "replay");
    be_b = 4'h1;
    acc(0, 1'b1, 12'h310, 32'hFFFF_FFFF, d);
    be_b = 4'hF;
    rchk(0, 12'h310, 32'h1234_56FF, "be_lane");
    acc(0, 1'b1, 12'h0E0, 32'h0000_0310, d);
    rchk(0, 12'h0E4, 32'h1234_56FF, "window");
    acc(0, 1'b1, 12'h0E0, 32'h0000_00E4, d);
    rchk(0, 12'h0E4, 32'h0000_0000, "window_self");
    acc(0, 1'b1, 12'h200, 32'hFFFF_FFFF, d);
    rchk(0, 12'h200, 32'h0000_0000, "rsvd_200");
    acc(1, 1'b1, 12'hFFC, 32'hFFFF_FFFF, d);
    rchk(1, 12'hFFC, 32'h0000_0000, "rsvd_ffc");
    $display("t_map done");
  endtask : t_map

  task automatic t_smb_eep;
    acc(1, 1'b1, 12'h118, 32'hC0DE_0001, d);
    rchk(1, 12'h118, 32'hC0DE_0001, "ctl_smb");
    acc(2, 1'b1, 12'h118, 32'hFFFF_FFFF, d);
    rchk(0, 12'h118, 32'hC0DE_0001, "ctl_noload");
    acc(2, 1'b1, 12'h108, 32'h0000_00F0, d);
    rchk(0, 12'h108, 32'h0000_00F0, "mask_load");
    $display("t_smb_eep done");
  endtask : t_smb_eep

  task automatic t_sub;
    acc(1, 1'b1, 12'h0B0, 32'h0000_D800, d);
    acc(1, 1'b1, 12'h0A8, 32'h0000_B000, d);
    acc(0, 1'b0, 12'h0A8, 32'h0, d);
    chk("next_on", 32'h0000_00B0, {24'h0, d[15:8]});
    @(negedge clk);
    sub_en = 1'b1;
    acc(0, 1'b0, 12'h0A8, 32'h0, d);
    chk("next_sub", 32'h0000_00D8, {24'h0, d[15:8]});
    rchk(0, 12'h0B0, 32'h0000_0000, "exp_hid");
    rchk(0, 12'h100, 32'h0000_0000, "aer_hid");
    rchk(1, 12'h310, 32'h0000_0000, "ext_hid");
    acc(0, 1'b1, 12'h118, 32'h0000_0000, d);
    @(negedge clk);
    sub_en = 1'b0;
    rchk(0, 12'h118, 32'hC0DE_0001, "ext_nowr");
    $display("t_sub done");
  endtask : t_sub

  task automatic t_mode;
    @(negedge clk);
    tmode = 1'b0;
    rchk(0, 12'h100, 32'h0000_0000, "opaque_cfg");
    rchk(1, 12'h150, 32'h0000_0000, "opaque_smb");
    @(negedge clk);
    tmode = 1'b1;
    rchk(0, 12'h150, 32'h0001_0002, "visible");
    $display("t_mode done");
  endtask : t_mode

  task automatic t_events;
    acc(0, 1'b1, 12'h114, 32'h0000_0001, d);
    @(negedge clk);
    fev = 32'h0000_0011;
    rev = 32'h0000_0001;
    sev = 32'h0000_0002;
    @(negedge clk);
    fev = '0;
    rev = '0;
    sev = '0;
    @(negedge clk);
    chk("fpend", 1, fpend);
    chk("rpend_masked", 0, rpend);
    rchk(0, 12'h104, 32'h0000_0011, "fatal_sts");
    rchk(0, 12'h110, 32'h0000_0001, "recov_sts");
    rchk(0, 12'h12C, 32'h0000_0002, "sec_sts");
    acc(0, 1'b1, 12'h114, 32'h0000_0000, d);
    chk("rpend", 1, rpend);
    acc(0, 1'b1, 12'h104, 32'h0000_0011, d);
    rchk(0, 12'h104, 32'h0000_0000, "fatal_w1c");
    chk("fpend_clr", 0, fpend);
    // Event and clear taken on the same edge: the set wins
    fork
      acc(0, 1'b1, 12'h104, 32'h0000_0001, d);
      begin
        @(negedge clk);
        fev = 32'h0000_0001;
        @(negedge clk);
        fev = 32'h0000_0000;
      end
    join
    rchk(0, 12'h104, 32'h0000_0001, "set_wins");
    $display("t_events done");
  endtask : t_events

  task automatic t_vpd;
    int n;
    acc(0, 1'b1, 12'h0DC, 32'hA5A5_0F0F, d);
    acc(0, 1'b1, 12'h0D8, 32'h8005_0000, d);
    chk("req", 1, vpd_req);
    chk("dir", 1, vpd_write);
    chk("addr", 5, vpd_addr);
    chk("wdata", 32'hA5A5_0F0F, vpd_wdata);
    for (n = 0; n < 40 && vpd_req !== 1'b0; n++) @(negedge clk);
    acc(0, 1'b0, 12'h0D8, 32'h0, d);
    chk("flag_wr", 0, d[31]);
    acc(0, 1'b1, 12'h0D8, 32'h0007_0000, d);
    chk("rd_dir", 0, vpd_write);
    for (n = 0; n < 40 && vpd_req !== 1'b0; n++) @(negedge clk);
    rchk(0, 12'h0DC, 32'h5A00_0007, "rd_word");
    acc(0, 1'b0, 12'h0D8, 32'h0, d);
    chk("flag_rd", 1, d[31]);
    $display("t_vpd done");
  endtask : t_vpd

  // Reset in mid-run restores the reset words and clears summaries
  task automatic t_reset;
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rchk(0, 12'h310, 32'h0000_0000, "rst_replay");
    rchk(1, 12'h100, 32'h1501_0001, "rst_aer");
    chk("rst_fpend", 0, fpend);
    $display("t_reset done");
  endtask : t_reset

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Clock at 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog well past the expected run
  initial begin
    #100000;
    failures++;
    print_verdict();
  end

  // Reset then the scenario sequence
  initial begin
    failures = 0;
    n_tests = 0;
    {rstn, sub_en, we_b, req_b, a_b, wd_b, fev, rev, sev} = '0;
    tmode = 1'b1;
    be_b = 4'hF;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    t_map();
    t_smb_eep();
    t_sub();
    t_mode();
    t_events();
    t_vpd();
    t_reset();
    print_verdict();
  end
endmodule : test_bridge_upper_and_extended_config_space
`default_nettype wire

// *** testbench/ucs_vpd_model.sv ***
// EEPROM engine stand-in that answers product-data transfers.
// Assumes vpd_req stays high until the cycle after vpd_done.
`timescale 1ns/1ps
`default_nettype none
module ucs_vpd_model #(
  parameter int DELAY = 5
) (
  // Clock
  input  wire logic        clk,
  // Transfer request from the bank
  input  wire logic        vpd_req,
  input  wire logic        vpd_write,
  input  wire logic [14:0] vpd_addr,
  // Completion back to the bank
  output logic             vpd_done,
  output logic [31:0]      vpd_rdata
);
  int cnt;

  // Reset-free start values
  initial begin
    cnt = 0;
    vpd_done = 1'b0;
    vpd_rdata = 32'h0000_0000;
  end

  // Count busy cycles, answer once; data scrambles off the done cycle
  always @(posedge clk) begin
    vpd_done  <= 1'b0;
    vpd_rdata <= ~vpd_rdata;
    cnt       <= (!vpd_req || vpd_done) ? 0 : cnt + 1;
    if (vpd_req && !vpd_done && cnt == DELAY) begin
      vpd_done  <= 1'b1;
      vpd_rdata <= vpd_write ? ~vpd_rdata : (32'h5A00_0000 | {17'h0, vpd_addr});
    end
  end
endmodule : ucs_vpd_model
`default_nettype wire
